// file: src/wssc_pkg.sv
// constants for the wiper step and shift control block
// assumes a byte-wide command port fed by an i2c target front end
package wssc_pkg;
   // target address prefix, straps fill the two low bits
   localparam logic [4:0] WSSC_ADDR_PREFIX = 5'h0b;
   // instruction byte field positions
   localparam int WSSC_MODE_BIT = 7;
   localparam int WSSC_BANK_BIT = 5;
   localparam int WSSC_CMD_MSB = 6;
   localparam int WSSC_CMD_LSB = 3;
   localparam int WSSC_CH_MSB = 2;
   localparam int WSSC_REG_MSB = 4;
   // channel select codes
   localparam logic [2:0] WSSC_CH_ONE = 3'h1;
   localparam logic [2:0] WSSC_CH_TWO = 3'h3;
   localparam logic [4:0] WSSC_REG_ONE = 5'h01;
   localparam logic [4:0] WSSC_REG_TWO = 5'h03;
   // quick command codes
   localparam logic [3:0] WSSC_CMD_NOP = 4'h0;
   localparam logic [3:0] WSSC_CMD_HALVE_ONE = 4'h3;
   localparam logic [3:0] WSSC_CMD_HALVE_ALL = 4'h4;
   localparam logic [3:0] WSSC_CMD_DEC_ONE = 4'h5;
   localparam logic [3:0] WSSC_CMD_DEC_ALL = 4'h6;
   localparam logic [3:0] WSSC_CMD_DBL_ONE = 4'h8;
   localparam logic [3:0] WSSC_CMD_DBL_ALL = 4'h9;
   localparam logic [3:0] WSSC_CMD_INC_ONE = 4'ha;
   localparam logic [3:0] WSSC_CMD_INC_ALL = 4'hb;
   // setting width limits and default
   localparam int WSSC_WIDTH_DEFAULT = 8;
   localparam int WSSC_WIDTH_MAX = 8;
   // sequencer states, one-hot
   typedef enum logic [1:0] {
      WSSC_ST_IDLE = 2'b01,
      WSSC_ST_APPLY = 2'b10
   } wssc_state_type;
endpackage

// file: src/wssc_core.sv
// wiper step and shift control: two wiper settings, quick commands,
// register writes, write protect, address match and tap decode.
// assumes an i2c target front end on core_clk presents each decoded
// write (target address, instruction byte, data byte) as one pulse.
// write protect and straps are asynchronous pins, synchronised here;
// nonvolatile store, readback and bus framing sit outside this block.
//
// Overview of operation
// RULE1: increment and decrement commands move a setting by one code.
// RULE2: plus 6 dB shifts left (double), minus 6 dB shifts right (halve).
// RULE3: 6 dB commands hit one chosen channel or both at once.
// RULE4: doubling from zero tops out in nine, halving from full in eight.
// RULE5: low write-protect pin blocks writes; reset default is protected.
// RULE6: high write-protect pin lets writes through normally.
// RULE7: answer only address prefix 01011 followed by the two strap levels.
// RULE8: setting decodes to exactly one of 64 or 256 taps.
// RULE9: code zero selects the bottom tap, each code one tap higher.
// RULE10: exactly one tap switch on; both end switches always on.
// RULE11: codes 3/4 halve, 5/6 decrement, 8/9 double, 10/11 increment.
// RULE12: command channel field 001 is channel one, 011 channel two.
// RULE13: instruction msb high means command, low means register write.
// RULE14: single steps saturate at full scale and at zero.
`timescale 1ns/100ps
module wssc_core
   import wssc_pkg::*;
#(
   parameter int WIDTH = WSSC_WIDTH_DEFAULT // 6 or 8 bit setting
) (
   input wire logic core_clk, // 25 MHz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic req_valid, // one-cycle write request
   input wire logic [6:0] req_target, // received target address
   input wire logic [7:0] req_instr, // instruction byte
   input wire logic [7:0] req_data, // data byte
   input wire logic wp_n_pin, // write protect pin, active low
   input wire logic strap_high_pin, // address_strap_high pin
   input wire logic strap_low_pin, // address_strap_low pin
   output logic req_ready, // high when a request is taken
   output logic req_hit, // pulse: address matched
   output logic req_done, // pulse: request carried out
   output logic req_refused, // pulse: request rejected
   output logic [WIDTH-1:0] wiper_channel_one, // setting, channel one
   output logic [WIDTH-1:0] wiper_channel_two, // setting, channel two
   output logic [(1<<WIDTH)-1:0] tap_sel_one, // one-hot taps, channel one
   output logic [(1<<WIDTH)-1:0] tap_sel_two, // one-hot taps, channel two
   output logic end_switch_a, // top end switch enable
   output logic end_switch_b // bottom end switch enable
);
   localparam int TAPS = 1 << WIDTH;
   localparam logic [WIDTH-1:0] FULL = {WIDTH{1'b1}};
   localparam logic [WIDTH-1:0] MID = {1'b1, {(WIDTH-1){1'b0}}};
   // reset taps are the one-hot image of MID, bit TAPS/2
   localparam logic [TAPS-1:0] TAP_MID = {{(TAPS/2-1){1'b0}}, 1'b1,
      {(TAPS/2){1'b0}}};

   // the data byte and decode cannot serve settings wider than 8 bits
   // and the shift logic needs at least two bits to have a body
   if (WIDTH < 2 || WIDTH > WSSC_WIDTH_MAX) begin : g_width_check
      $error("wssc_core: WIDTH must be 2 to 8");
   end

   typedef struct packed {
      // sequencer
      wssc_state_type state;
      // two-flop synchronisers for the three pins
      logic wp_s1;
      logic wp_s2;
      logic sh_s1;
      logic sh_s2;
      logic sl_s1;
      logic sl_s2;
      // request bytes latched on the hit
      logic [7:0] instr;
      logic [7:0] data;
      // ready level and answer pulses
      logic ready;
      logic hit;
      logic done;
      logic refused;
      // settings and their decoded taps
      logic [WIDTH-1:0] wiper_one;
      logic [WIDTH-1:0] wiper_two;
      logic [TAPS-1:0] tap_one;
      logic [TAPS-1:0] tap_two;
      // end switches, held on
      logic end_a;
      logic end_b;
   } wssc_regs_type;

   // registered state and its next value
   wssc_regs_type s_reg;
   wssc_regs_type s_next;

   // one quick command applied to one setting
   function automatic logic [WIDTH-1:0] step_code(
      input logic [3:0] op,
      input logic [WIDTH-1:0] val
   );
      logic [WIDTH-1:0] res;
      res = val;
      case (op)
         WSSC_CMD_INC_ONE, WSSC_CMD_INC_ALL: begin
            if (val != FULL) begin // RULE14
               res = val + 1'b1; // RULE1
            end
         end
         WSSC_CMD_DEC_ONE, WSSC_CMD_DEC_ALL: begin
            if (val != '0) begin // RULE14
               res = val - 1'b1; // RULE1
            end
         end
         // zero seeds a one and an overflowing shift clamps to full,
         // so nine doublings always reach the top
         WSSC_CMD_DBL_ONE, WSSC_CMD_DBL_ALL: begin
            if (val == '0) begin
               res = {{(WIDTH-1){1'b0}}, 1'b1}; // RULE4
            end else if (val[WIDTH-1]) begin
               res = FULL; // RULE4
            end else begin
               res = {val[WIDTH-2:0], 1'b0}; // RULE2
            end
         end
         // halving needs no clamp, the msb simply fills with zero
         WSSC_CMD_HALVE_ONE, WSSC_CMD_HALVE_ALL: begin
            res = {1'b0, val[WIDTH-1:1]}; // RULE2 RULE4
         end
         default: begin
            res = val;
         end
      endcase
      return res;
   endfunction

   // setting to one-hot tap enable, bit 0 is the bottom tap
   function automatic logic [TAPS-1:0] tap_decode(
      input logic [WIDTH-1:0] val
   );
      logic [TAPS-1:0] hot;
      hot = '0;
      // bit index equals code, so the taps walk up one per code
      hot[val] = 1'b1; // RULE8 RULE9 RULE10
      return hot;
   endfunction

   // quick commands that act on both channels at once
   function automatic logic is_all_op(
      input logic [3:0] op
   );
      return op == WSSC_CMD_HALVE_ALL || op == WSSC_CMD_DEC_ALL ||
         op == WSSC_CMD_DBL_ALL || op == WSSC_CMD_INC_ALL; // RULE11
   endfunction

   // quick commands that act on the channel named in the low field
   function automatic logic is_one_op(
      input logic [3:0] op
   );
      return op == WSSC_CMD_HALVE_ONE || op == WSSC_CMD_DEC_ONE ||
         op == WSSC_CMD_DBL_ONE || op == WSSC_CMD_INC_ONE; // RULE11
   endfunction

   // register mode write to one wiper: bank bit clear, address match
   function automatic logic wiper_reg_sel(
      input logic bank,
      input logic [4:0] sel,
      input logic [4:0] want
   );
      return !bank && sel == want; // RULE13
   endfunction

   // trade-off: a request takes two cycles, so the decode works on the
   // latched instruction instead of the live request bytes
   // next-state logic for the whole block
   always_comb begin
      logic [3:0] op;
      logic [2:0] ch;
      logic [4:0] reg_sel;
      logic is_all;
      logic is_one;
      op = '0;
      ch = '0;
      reg_sel = '0;
      is_all = 1'b0;
      is_one = 1'b0;
      s_next = s_reg;
      s_next.hit = 1'b0;
      s_next.done = 1'b0;
      s_next.refused = 1'b0;
      // pin synchronisers, second stage is the only reader of the first
      s_next.wp_s1 = wp_n_pin;
      s_next.wp_s2 = s_reg.wp_s1;
      s_next.sh_s1 = strap_high_pin;
      s_next.sh_s2 = s_reg.sh_s1;
      s_next.sl_s1 = strap_low_pin;
      s_next.sl_s2 = s_reg.sl_s1;
      case (s_reg.state)
         WSSC_ST_IDLE: begin
            // straps are read through the synchronisers, so a strap
            // change takes two edges to move the address
            // other targets are ignored without any answer
            if (req_valid && req_target ==
                  {WSSC_ADDR_PREFIX, s_reg.sh_s2, s_reg.sl_s2}) begin // RULE7
               s_next.instr = req_instr;
               s_next.data = req_data;
               s_next.hit = 1'b1;
               s_next.state = WSSC_ST_APPLY;
            end
         end
         WSSC_ST_APPLY: begin
            s_next.state = WSSC_ST_IDLE;
            // decode the latched instruction; all-channel codes
            // ignore the channel field
            op = s_reg.instr[WSSC_CMD_MSB:WSSC_CMD_LSB];
            ch = s_reg.instr[WSSC_CH_MSB:0];
            reg_sel = s_reg.instr[WSSC_REG_MSB:0];
            is_all = is_all_op(op); // RULE11
            is_one = is_one_op(op); // RULE11
            // protect blocks every request, a nop too, so nothing
            // slips through while the pin is still settling
            if (!s_reg.wp_s2) begin
               s_next.refused = 1'b1; // RULE5
            end else if (s_reg.instr[WSSC_MODE_BIT]) begin // RULE13 RULE6
               if (is_all) begin
                  // both channels change on the same edge
                  s_next.wiper_one = step_code(op, s_reg.wiper_one); // RULE3
                  s_next.wiper_two = step_code(op, s_reg.wiper_two); // RULE3
                  s_next.done = 1'b1;
               end else if (is_one && ch == WSSC_CH_ONE) begin // RULE12
                  s_next.wiper_one = step_code(op, s_reg.wiper_one); // RULE3
                  s_next.done = 1'b1;
               end else if (is_one && ch == WSSC_CH_TWO) begin // RULE12
                  s_next.wiper_two = step_code(op, s_reg.wiper_two); // RULE3
                  s_next.done = 1'b1;
               end else if (op == WSSC_CMD_NOP) begin
                  s_next.done = 1'b1;
               end else begin
                  // store/restore and reserved codes live elsewhere
                  s_next.refused = 1'b1;
               end
            end else if (wiper_reg_sel(s_reg.instr[WSSC_BANK_BIT], reg_sel,
                  WSSC_REG_ONE)) begin // RULE13
               // upper data bits drop out for a narrow setting
               s_next.wiper_one = s_reg.data[WIDTH-1:0];
               s_next.done = 1'b1;
            end else if (wiper_reg_sel(s_reg.instr[WSSC_BANK_BIT], reg_sel,
                  WSSC_REG_TWO)) begin // RULE13
               s_next.wiper_two = s_reg.data[WIDTH-1:0];
               s_next.done = 1'b1;
            end else begin
               s_next.refused = 1'b1;
            end
         end
         // an illegal state word falls back to idle
         default: begin
            s_next.state = WSSC_ST_IDLE;
         end
      endcase
      // ready drops only for the cycle in which a request is applied
      s_next.ready = s_next.state == WSSC_ST_IDLE;
      // taps follow the new setting in the same edge
      s_next.tap_one = tap_decode(s_next.wiper_one); // RULE8 RULE10
      s_next.tap_two = tap_decode(s_next.wiper_two); // RULE8 RULE10
      s_next.end_a = 1'b1; // RULE10
      s_next.end_b = 1'b1; // RULE10
   end

   // state register; wp sync resets low so the block starts protected
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // idle, but not ready until the first edge after release
         s_reg.state <= WSSC_ST_IDLE;
         s_reg.wp_s1 <= 1'b0; // RULE5
         s_reg.wp_s2 <= 1'b0; // RULE5
         s_reg.sh_s1 <= 1'b0;
         s_reg.sh_s2 <= 1'b0;
         s_reg.sl_s1 <= 1'b0;
         s_reg.sl_s2 <= 1'b0;
         // nothing latched and no answer pending
         s_reg.instr <= 8'h00;
         s_reg.data <= 8'h00;
         s_reg.ready <= 1'b0;
         s_reg.hit <= 1'b0;
         s_reg.done <= 1'b0;
         s_reg.refused <= 1'b0;
         // settings start at midscale with taps to match
         s_reg.wiper_one <= MID;
         s_reg.wiper_two <= MID;
         s_reg.tap_one <= TAP_MID;
         s_reg.tap_two <= TAP_MID;
         s_reg.end_a <= 1'b1;
         s_reg.end_b <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state flops
   // no logic between flops and pins, so the taps never glitch
   assign req_ready = s_reg.ready;
   assign req_hit = s_reg.hit;
   assign req_done = s_reg.done;
   assign req_refused = s_reg.refused;
   assign wiper_channel_one = s_reg.wiper_one;
   assign wiper_channel_two = s_reg.wiper_two;
   assign tap_sel_one = s_reg.tap_one;
   assign tap_sel_two = s_reg.tap_two;
   assign end_switch_a = s_reg.end_a;
   assign end_switch_b = s_reg.end_b;
endmodule // wssc_core

// file: sim/wssc_sva.sv
// checker for the wiper step and shift control core
// assumes it is bound to wssc_core and sees only its ports
`timescale 1ns/100ps
module wssc_sva
   import wssc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic core_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic req_valid, // request strobe
   input wire logic req_ready, // core idle
   input wire logic [6:0] req_target, // target address
   input wire logic [7:0] req_instr, // instruction byte
   input wire logic req_hit, // address matched
   input wire logic req_done, // carried out
   input wire logic req_refused, // rejected
   input wire logic [WIDTH-1:0] wiper_channel_one, // setting one
   input wire logic [WIDTH-1:0] wiper_channel_two, // setting two
   input wire logic [(1<<WIDTH)-1:0] tap_sel_one, // taps one
   input wire logic [(1<<WIDTH)-1:0] tap_sel_two, // taps two
   input wire logic end_switch_a, // end switch
   input wire logic end_switch_b // end switch
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // every hit gets exactly one answer, one cycle later
   answer_follows_a: assert property (req_hit |=> req_done != req_refused)
      else $error("hit without a single answer");
   hit_cause_a: assert property (req_hit |-> $past(req_valid) &&
      $past(req_ready) && ($past(req_target) >> 2) == 7'h0b)
      else $error("hit without a matching request");
   tap_one_a: assert property ($onehot(tap_sel_one) &&
      tap_sel_one[wiper_channel_one]) else $error("tap one wrong");
   tap_two_a: assert property ($onehot(tap_sel_two) &&
      tap_sel_two[wiper_channel_two]) else $error("tap two wrong");
   ends_on_a: assert property (end_switch_a && end_switch_b)
      else $error("end switch off");
   refuse_hold_a: assert property (req_refused |->
      $stable(wiper_channel_one) && $stable(wiper_channel_two))
      else $error("refused request moved a wiper");
   change_done_a: assert property ($changed(wiper_channel_one) ||
      $changed(wiper_channel_two) |-> req_done)
      else $error("wiper moved without done");
   // the command is known one cycle before done, on the hit
   inc_one_a: assert property (req_hit && $past(req_instr) == 8'hd1 ##1
      req_done |-> wiper_channel_one == (&$past(wiper_channel_one) ?
      $past(wiper_channel_one) : $past(wiper_channel_one) + 1'b1))
      else $error("increment wrong");
   halve_all_a: assert property (req_hit &&
      ($past(req_instr) >> 3) == 8'h14 ##1 req_done |->
      wiper_channel_one == $past(wiper_channel_one) >> 1 &&
      wiper_channel_two == $past(wiper_channel_two) >> 1)
      else $error("halve all wrong");
   double_two_a: assert property (req_hit && $past(req_instr) == 8'hc3
      ##1 req_done |-> wiper_channel_two == ($past(wiper_channel_two) == '0
      ? {{(WIDTH-1){1'b0}}, 1'b1} : ($past(wiper_channel_two) >> (WIDTH-1))
      != 0 ? {WIDTH{1'b1}} : $past(wiper_channel_two) << 1))
      else $error("double two wrong");
   cv_refused: cover property (req_refused);
   cv_full: cover property (req_done && &wiper_channel_one);
   cv_zero: cover property (req_done && wiper_channel_one == '0);
endmodule // wssc_sva

bind wssc_core wssc_sva #(.WIDTH(WIDTH)) wssc_sva_inst (.core_clk(core_clk),
   .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
   .req_target(req_target), .req_instr(req_instr), .req_hit(req_hit),
   .req_done(req_done), .req_refused(req_refused),
   .wiper_channel_one(wiper_channel_one),
   .wiper_channel_two(wiper_channel_two), .tap_sel_one(tap_sel_one),
   .tap_sel_two(tap_sel_two), .end_switch_a(end_switch_a),
   .end_switch_b(end_switch_b));

// file: sim/wssc_host.sv
// request driver standing in for the bus controller front end
// assumes one request at a time, taken on an edge with ready high
`timescale 1ns/100ps
module wssc_host (
   input wire logic core_clk, // system clock
   input wire logic req_ready, // core idle
   output logic req_valid, // one-cycle strobe
   output logic [6:0] req_target, // target address
   output logic [7:0] req_instr, // instruction byte
   output logic [7:0] req_data // data byte
);
   initial begin
      req_valid = 1'b0;
      req_target = 7'h00;
      req_instr = 8'h00;
      req_data = 8'h00;
   end
   // wait for ready, then strobe for exactly one edge
   task automatic send(input logic [6:0] tgt, input logic [7:0] ins,
      input logic [7:0] dat, output bit ok);
      ok = 0;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge core_clk);
         #1;
         ok = req_ready;
      end
      if (ok) begin
         req_valid = 1'b1;
         req_target = tgt;
         req_instr = ins;
         req_data = dat;
         @(posedge core_clk);
         #1;
         req_valid = 1'b0;
         // released fields show junk, not the last value
         req_target = ~tgt;
         req_instr = ~ins;
         req_data = ~dat;
      end
   endtask
endmodule // wssc_host

// file: sim/tb.sv
// self-checking bench: directed and random requests against a model
// assumes wssc_core at its default 8-bit width
`timescale 1ns/100ps
module tb;
   import wssc_pkg::*;
   logic core_clk, rst_n, wp_n_pin, strap_high_pin, strap_low_pin;
   logic req_valid, req_ready, req_hit, req_done, req_refused, end_a, end_b;
   logic [6:0] req_target;
   logic [7:0] req_instr, req_data, w1, w2, m1, m2;
   logic [255:0] t1, t2;
   logic [17:0] q[$];
   int n_mismatch, cmp_count, i;
   wssc_host wssc_host_inst (.core_clk(core_clk), .req_ready(req_ready),
      .req_valid(req_valid), .req_target(req_target),
      .req_instr(req_instr), .req_data(req_data));
   wssc_core wssc_core_inst (.core_clk(core_clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_target(req_target), .req_instr(req_instr),
      .req_data(req_data), .wp_n_pin(wp_n_pin),
      .strap_high_pin(strap_high_pin), .strap_low_pin(strap_low_pin),
      .req_ready(req_ready), .req_hit(req_hit), .req_done(req_done),
      .req_refused(req_refused), .wiper_channel_one(w1),
      .wiper_channel_two(w2), .tap_sel_one(t1), .tap_sel_two(t2),
      .end_switch_a(end_a), .end_switch_b(end_b));
   task automatic check(string what, logic [255:0] seen, logic [255:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one command applied to a model setting, saturating at both ends
   function automatic logic [7:0] step(logic [3:0] op, logic [7:0] v);
      case (op)
         4'h3, 4'h4: return v >> 1;
         4'h5, 4'h6: return (v == 8'h00) ? v : v - 8'h01;
         4'h8, 4'h9: return (v == 8'h00) ? 8'h01 : v[7] ? 8'hff : v << 1;
         4'ha, 4'hb: return (&v) ? v : v + 8'h01;
         default: return v;
      endcase
   endfunction
   // send one request and note the expected answer when it targets us
   task automatic issue(logic [7:0] ins, logic [7:0] dat, bit hit);
      logic [3:0] op;
      logic rf;
      bit ok;
      op = ins[6:3];
      wssc_host_inst.send({5'h0b, strap_high_pin ^ !hit, strap_low_pin},
         ins, dat, ok);
      if (!ok) begin
         n_mismatch++;
         finish_test();
      end
      if (hit) begin
         rf = !wp_n_pin;
         if (ins[7]) begin
            if (!(op inside {0, 3, 4, 5, 6, 8, 9, 10, 11})) rf = 1;
            if ((op inside {3, 5, 8, 10}) && !(ins[2:0] inside {1, 3})) rf = 1;
         end else if (ins[5] || !(ins[4:0] inside {1, 3})) rf = 1;
         if (!rf && !ins[7]) begin
            if (ins[1]) m2 = dat;
            else m1 = dat;
         end else if (!rf && (op inside {4, 6, 9, 11})) begin
            m1 = step(op, m1);
            m2 = step(op, m2);
         end else if (!rf && ins[1]) m2 = step(op, m2);
         else if (!rf) m1 = step(op, m1);
         q.push_back({!rf, rf, m1, m2});
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // watchdog: a hang counts as a mismatch
   initial begin
      #2000000;
      n_mismatch++;
      finish_test();
   end
   // monitor: each answer takes the oldest note off the queue
   always @(posedge core_clk) begin
      logic [17:0] e;
      #2;
      if (req_done === 1'b1 || req_refused === 1'b1) begin
         if (q.size() == 0) check("answer count", 1, 0);
         else begin
            e = q.pop_front();
            check("answer", {req_done, req_refused, w1, w2}, e);
            check("tap one", t1, 256'h1 << e[15:8]);
            check("tap two", t2, 256'h1 << e[7:0]);
            check("end switches", {end_a, end_b}, 2'b11);
         end
      end
   end
   initial begin
      rst_n = 1'b0;
      wp_n_pin = 1'b0;
      m1 = 8'h80;
      m2 = 8'h80;
      i = $urandom(32'h954d);
      {strap_high_pin, strap_low_pin} = 2'($urandom);
      repeat (4) @(posedge core_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      issue(8'hd1, 8'h00, 1);
      issue(8'h80, 8'h00, 1);
      #1 wp_n_pin = 1'b1;
      repeat (3) @(posedge core_clk);
      // every code on channel one, channel two and a bad channel
      for (i = 0; i < 48; i++) issue({1'b1, i[3:0], (i < 16) ? 3'h1 :
         (i < 32) ? 3'h3 : 3'h6}, 8'h00, 1);
      issue(8'h01, 8'h00, 1);
      repeat (9) issue(8'hc1, 8'h00, 1);
      repeat (3) @(posedge core_clk);
      check("after doubles", w1, 8'hff);
      repeat (8) issue(8'h99, 8'h00, 1);
      repeat (3) @(posedge core_clk);
      check("after halves", w1, 8'h00);
      issue(8'h03, 8'hff, 1);
      issue(8'hd3, 8'h00, 1);
      issue(8'ha9, 8'h00, 1);
      issue(8'hd1, 8'h00, 0);
      issue(8'h23, 8'h55, 1);
      // random traffic with occasional protect changes
      for (i = 0; i < 300; i++) begin
         if ($urandom % 16 == 0) begin
            repeat (3) @(posedge core_clk);
            #1 wp_n_pin = ~wp_n_pin;
            repeat (3) @(posedge core_clk);
         end
         issue(8'($urandom) & 8'hbf | 8'h80 * ($urandom % 4 != 0),
            8'($urandom), $urandom % 8 != 0);
      end
      for (i = 0; i < 10 && q.size() != 0; i++) @(posedge core_clk);
      check("queue drained", q.size(), 0);
      finish_test();
   end
endmodule // tb
